// >>> core/sah_device.sv
// converter end: edge sequencer, conversion timer, byte-wide output
`timescale 1ns/1ps
// Function
// - first edge, select low: power up, acquire
// - second edge select level picks reference power-down
// - second edge starts conversion
// - third edge, select high: drive result
// - end-of-conversion falls when conversion done
// - conversion completes within 4.7 us
// - host leaves 2 us acquisition
// - host stays below 135 ksps
// - sixteen bits over eight shared lines
// - byte select one gives high byte
// - host reads both bytes, waits release
module sah_device #(
  parameter int unsigned CONV_CYC = sah_pkg::CONV_CYCLES
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         clk_en,
  sah_if.dev                                pins,
  input  wire logic [sah_pkg::RESULT_W-1:0] sample_in,
  output logic                              powered,
  output logic                              ref_powered,
  output logic                              acquiring
);
  import sah_pkg::*;

  // ************
  // edge detect
  // ************
  logic                cs_fall;
  logic                cs_rise;
  sah_phase_t          ph_q;
  logic [CNT_W-1:0]    cnt_q;
  logic [RESULT_W-1:0] result_q;
  logic                reading_q;
  logic                eoc_n_q;
  logic                ref_down_q;
  logic                edge2;
  logic                conv_end;
  logic                read_start;
  logic                read_end;
  logic                powered_q;
  logic                ref_powered_q;
  logic                acquiring_q;

  // idle level of the strobe is high, so no false edge follows reset
  sah_edge_det #(
    .IDLE_LVL (1'b1)
  ) sah_edge_det_i (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .level  (pins.cs_n),
    .fall   (cs_fall),
    .rise   (cs_rise)
  );

  assign edge2      = (ph_q == SAH_PH_ACQ) & cs_fall;
  assign conv_end   = (ph_q == SAH_PH_CONV) & (cnt_q >= CNT_W'(CONV_CYC - 1));
  assign read_start = (ph_q == SAH_PH_DONE) & cs_fall & pins.read_conv;
  assign read_end   = (ph_q == SAH_PH_DONE) & cs_rise & reading_q;

  // ************
  // sequencer
  // ************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= SAH_PH_IDLE;
    end else if (clk_en) begin
      unique case (ph_q)
        SAH_PH_IDLE: begin
          if (cs_fall && !pins.read_conv) begin
            ph_q <= SAH_PH_ACQ;
          end
        end
        SAH_PH_ACQ: begin
          if (edge2) begin
            ph_q <= SAH_PH_CONV;
          end
        end
        SAH_PH_CONV: begin
          if (conv_end) begin
            ph_q <= SAH_PH_DONE;
          end
        end
        SAH_PH_DONE: begin
          if (read_end) begin
            ph_q <= SAH_PH_IDLE;
          end
        end
      endcase
    end
  end

  // ************
  // conversion timer
  // ************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      if (edge2) begin
        cnt_q <= '0;
      end else if ((ph_q == SAH_PH_CONV) && !conv_end) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // ************
  // reference and result
  // ************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_down_q <= 1'b0;
    end else if (clk_en) begin
      if (edge2) begin
        ref_down_q <= pins.read_conv;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= RESULT_RST;
    end else if (clk_en) begin
      if (conv_end) begin
        result_q <= sample_in;
      end
    end
  end

  // ************
  // end of conversion and read window
  // ************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eoc_n_q <= 1'b1;
    end else if (clk_en) begin
      if (conv_end) begin
        eoc_n_q <= 1'b0;
      end else if (read_end) begin
        eoc_n_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reading_q <= 1'b0;
    end else if (clk_en) begin
      if (read_start) begin
        reading_q <= 1'b1;
      end else if (read_end) begin
        reading_q <= 1'b0;
      end
    end
  end

  // ************
  // status outputs
  // ************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      powered_q     <= 1'b0;
      ref_powered_q <= 1'b1;
      acquiring_q   <= 1'b0;
    end else if (clk_en) begin
      powered_q     <= (ph_q != SAH_PH_IDLE);
      ref_powered_q <= ~(ref_down_q & (ph_q == SAH_PH_IDLE));
      acquiring_q   <= (ph_q == SAH_PH_ACQ);
    end
  end

  // ************
  // data lines
  // ************
  logic [BYTE_W-1:0] byte_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_q <= '0;
    end else if (clk_en) begin
      byte_q <= pins.high_byte_select ? result_q[RESULT_W-1:BYTE_W]
                                      : result_q[BYTE_W-1:0];
    end
  end

  assign pins.data_o  = byte_q;
  assign pins.data_oe = reading_q & ~pins.cs_n;
  assign pins.eoc_n   = eoc_n_q;
  assign powered      = powered_q;
  assign ref_powered  = ref_powered_q;
  assign acquiring    = acquiring_q;
endmodule

// ************
// strobe edge detector
// ************
module sah_edge_det #(
  parameter logic IDLE_LVL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic level,
  output logic      fall,
  output logic      rise
);
  logic lvl_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= IDLE_LVL;
    end else if (clk_en) begin
      lvl_q <= level;
    end
  end

  assign fall = lvl_q & ~level;
  assign rise = ~lvl_q & level;
endmodule

// >>> core/sah_pkg.sv
// shared constants and types for the converter sequencer and its host
package sah_pkg;
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned CONV_TIME_NS_X10 = 47;
  localparam int unsigned ACQ_TIME_NS      = 2000;
  localparam int unsigned MAX_RATE_KSPS    = 135;
  localparam int unsigned EOC_RISE_NS      = 40;
  localparam int unsigned CONV_CYCLES      = (CONV_TIME_NS_X10 * 100000) / CLK_PERIOD_PS;
  localparam int unsigned ACQ_CYCLES       = (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
  localparam int unsigned FRAME_CYCLES     = (1000000000 / MAX_RATE_KSPS + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
  localparam int unsigned BR_CYCLES        = (EOC_RISE_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
  localparam int unsigned RESULT_W         = 16;
  localparam int unsigned BYTE_W           = 8;
  localparam int unsigned CNT_W            = 12;
  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
  typedef enum logic [1:0] {SAH_PH_IDLE, SAH_PH_ACQ, SAH_PH_CONV, SAH_PH_DONE} sah_phase_t;
endpackage

// >>> core/sah_if.sv
// parallel pins between converter and host
`timescale 1ns/1ps
interface sah_if;
  logic       cs_n;
  logic       read_conv;
  logic       high_byte_select;
  logic       eoc_n;
  logic [7:0] data_o;
  logic       data_oe;
  wire  [7:0] data_bus = data_oe ? data_o : 8'hFF;
  modport dev  (input cs_n, input read_conv, input high_byte_select,
                output eoc_n, output data_o, output data_oe);
  modport host (output cs_n, output read_conv, output high_byte_select,
                input eoc_n, input data_o, input data_oe);
endinterface

// >>> core/sah_host.sv
// host end: drives the three-edge acquire, convert, read sequence
`timescale 1ns/1ps
module sah_host #(
  parameter int unsigned ACQ_CYC   = sah_pkg::ACQ_CYCLES,
  parameter int unsigned FRAME_CYC = sah_pkg::FRAME_CYCLES
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         clk_en,
  sah_if.host                               pins,
  input  wire logic                         start,
  input  wire logic                         ref_off,
  output logic                              busy,
  output logic                              done,
  output logic [sah_pkg::RESULT_W-1:0]      result
);
  import sah_pkg::*;

  typedef enum logic [3:0] {
    SAH_H_IDLE, SAH_H_E1, SAH_H_ACQ, SAH_H_E2, SAH_H_WAIT,
    SAH_H_E3, SAH_H_HI, SAH_H_LO, SAH_H_REL, SAH_H_GAP
  } sah_host_st_t;

  sah_host_st_t st_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] frame_q;
  logic [RESULT_W-1:0] res_q;
  logic cs_n_q;
  logic rc_q;
  logic hb_q;
  logic done_q;

  // ************
  // frame pacing
  // ************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_q <= '0;
    end else if (clk_en) begin
      if (st_q == SAH_H_IDLE && start && frame_q == '0) begin
        frame_q <= CNT_W'(FRAME_CYC - 1);
      end else if (frame_q != '0) begin
        frame_q <= frame_q - 1'b1;
      end
    end
  end

  // ************
  // sequence
  // ************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= SAH_H_IDLE;
      cnt_q  <= '0;
      cs_n_q <= 1'b1;
      rc_q   <= 1'b0;
      hb_q   <= 1'b1;
      res_q  <= RESULT_RST;
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      unique case (st_q)
        SAH_H_IDLE: if (start && frame_q == '0) begin
          cs_n_q <= 1'b0;
          rc_q   <= 1'b0;
          st_q   <= SAH_H_E1;
        end
        SAH_H_E1: begin
          cs_n_q <= 1'b1;
          cnt_q  <= '0;
          st_q   <= SAH_H_ACQ;
        end
        SAH_H_ACQ: if (cnt_q >= CNT_W'(ACQ_CYC)) begin
          cs_n_q <= 1'b0;
          rc_q   <= ref_off;
          st_q   <= SAH_H_E2;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
        SAH_H_E2: begin
          cs_n_q <= 1'b1;
          st_q   <= SAH_H_WAIT;
        end
        SAH_H_WAIT: if (!pins.eoc_n) begin
          cs_n_q <= 1'b0;
          rc_q   <= 1'b1;
          hb_q   <= 1'b1;
          st_q   <= SAH_H_E3;
        end
        SAH_H_E3: st_q <= SAH_H_HI;
        SAH_H_HI: begin
          res_q[RESULT_W-1:BYTE_W] <= pins.data_o;
          hb_q <= 1'b0;
          st_q <= SAH_H_LO;
          cnt_q <= '0;
        end
        SAH_H_LO: if (cnt_q == CNT_W'(1)) begin
          res_q[BYTE_W-1:0] <= pins.data_o;
          cs_n_q <= 1'b1;
          cnt_q  <= '0;
          st_q   <= SAH_H_REL;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
        SAH_H_REL: if (cnt_q >= CNT_W'(BR_CYCLES)) begin
          done_q <= 1'b1;
          st_q   <= SAH_H_IDLE;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
        default: st_q <= SAH_H_IDLE;
      endcase
    end
  end

  assign pins.cs_n             = cs_n_q;
  assign pins.read_conv        = rc_q;
  assign pins.high_byte_select = hb_q;
  assign busy                  = (st_q != SAH_H_IDLE);
  assign done                  = done_q;
  assign result                = res_q;
endmodule

// >>> bench/sah_monitor.sv
// concurrent checks on the converter-host parallel pins
`timescale 1ns/1ps
module sah_monitor #(
  parameter int unsigned CONV_CYC  = 20,
  parameter int unsigned ACQ_CYC   = 8,
  parameter int unsigned FRAME_CYC = 64
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic read_conv,
  input wire logic high_byte_select,
  input wire logic eoc_n,
  input wire logic data_oe
);
  localparam int CMAX = CONV_CYC + 2;
  logic        cs_q;
  logic [1:0]  ph_q;
  logic [11:0] gap_q;
  logic [11:0] frm_q;
  logic        fall;
  logic        acq;
  logic        conv;
  assign fall = cs_q && !cs_n;
  assign acq  = fall && eoc_n && ph_q == 2'h0;
  assign conv = fall && eoc_n && ph_q == 2'h1;
  // phase of the three-edge cycle and cycles since the last edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_q <= 1'b1;
      ph_q <= 2'h0;
      gap_q <= 12'h000;
      frm_q <= 12'hFFF;
    end else begin
      cs_q <= cs_n;
      gap_q <= fall ? 12'h000 : gap_q + 12'h001;
      if (acq) frm_q <= 12'h000;
      else if (~&frm_q) frm_q <= frm_q + 12'h001;
      if (!eoc_n) ph_q <= 2'h0;
      else if (acq || conv) ph_q <= ph_q + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_read;
    fall && read_conv && !eoc_n;
  endsequence
  sequence s_end;
    $rose(cs_n) && !eoc_n;
  endsequence
  chk_acq_level: assert property (acq |-> !read_conv)
    else $error("acquire edge taken with select high");
  chk_acq_gap: assert property (conv |-> gap_q >= ACQ_CYC - 1)
    else $error("acquisition too short");
  chk_conv_bound: assert property (conv |-> ##[1:CMAX] !eoc_n)
    else $error("conversion did not finish in time");
  chk_conv_time: assert property ($fell(eoc_n) |-> gap_q >= CONV_CYC - 2 && gap_q <= CMAX)
    else $error("end of conversion at wrong time");
  chk_read_drive: assert property (s_read |=> data_oe [*2])
    else $error("result not driven on read");
  chk_eoc_release: assert property (s_end |=> eoc_n && !data_oe)
    else $error("end of conversion not released");
  chk_oe_window: assert property (data_oe |-> !cs_n && !eoc_n)
    else $error("data lines driven outside a read");
  chk_frame_rate: assert property (acq |-> frm_q >= FRAME_CYC - 1)
    else $error("frames too close");
endmodule

// >>> bench/sar_adc_parallel_host_sequencer_test.sv
// self-checking bench: host and converter joined over the parallel pins
`timescale 1ns/1ps
module sar_adc_parallel_host_sequencer_test;
  import sah_pkg::*;
  logic                clk;
  logic                rst_n;
  logic                en;
  logic                start;
  logic                ref_off;
  logic                busy;
  logic                done;
  logic                ref_powered;
  logic                oe_d;
  logic                hb_d;
  logic [RESULT_W-1:0] sample_in;
  logic [RESULT_W-1:0] result;
  logic [RESULT_W:0]   exp_q[$];
  int                  n_errors;
  int                  n_tests;
  int                  seed;
  int                  cycles;
  sah_if bus ();
  sah_device #(.CONV_CYC(20)) sah_device_i (.clk(clk), .rst_n(rst_n), .clk_en(en),
    .pins(bus.dev), .sample_in(sample_in), .powered(), .ref_powered(ref_powered), .acquiring());
  sah_host #(.ACQ_CYC(8), .FRAME_CYC(64)) sah_host_i (.clk(clk), .rst_n(rst_n), .clk_en(en),
    .pins(bus.host), .start(start), .ref_off(ref_off), .busy(busy), .done(done), .result(result));
  sah_monitor sah_monitor_i (.clk(clk),
    .rst_n(rst_n), .cs_n(bus.cs_n), .read_conv(bus.read_conv), .eoc_n(bus.eoc_n),
    .high_byte_select(bus.high_byte_select), .data_oe(bus.data_oe));
  task automatic check(input logic [RESULT_W:0] got, input logic [RESULT_W:0] want);
    n_tests++;
    if (got !== want) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic run(input logic [RESULT_W-1:0] s, input logic r);
    @(posedge clk);
    // idle freeze: clock enable dropped at random between frames
    repeat (3) begin
      en <= 1'($random(seed));
      @(posedge clk);
    end
    en <= 1'b1;
    sample_in <= s;
    ref_off <= r;
    start <= 1'b1;
    exp_q.push_back({~r, s});
    @(posedge clk);
    while (!busy) @(posedge clk);
    start <= 1'b0;
    while (busy) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // result watcher: bus bytes during reads, whole result at done
  always @(posedge clk) begin
    oe_d <= bus.data_oe;
    hb_d <= bus.high_byte_select;
    if (bus.data_oe && oe_d) begin
      check({9'h000, bus.data_bus}, {9'h000, hb_d ? exp_q[0][15:8] : exp_q[0][7:0]});
    end
    if (done) begin
      check({ref_powered, result}, exp_q.pop_front());
    end
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    seed = 94682;
    cycles = 0;
    n_errors = 0;
    n_tests = 0;
    rst_n = 1'b0;
    en = 1'b1;
    start = 1'b0;
    ref_off = 1'b0;
    sample_in = 16'h0000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      run(i == 0 ? 16'hFFFF : i == 1 ? 16'h0000 : i == 2 ? 16'h8001 : 16'($random(seed)), i[0]);
    end
    repeat (8) @(posedge clk);
    close_out();
  end
endmodule
